/* verilog/lsu_top.sv */
// Load/store unit between the issue pipeline and the cached memory
`timescale 1ns/1ps

module lsu_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] isa_level,
  input wire logic big_endian,
  input wire logic [3:0] cop_usable,
  input wire logic link_break,
  input wire logic req_valid,
  input wire lsu_pkg::lsu_req_t req,
  output logic req_ready,
  output logic mem_valid,
  output lsu_pkg::lsu_mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic mem_rsp_valid,
  input wire logic [lsu_pkg::XLEN-1:0] mem_rdata,
  output logic wb_valid,
  output lsu_pkg::lsu_wb_t wb,
  output logic exc_valid,
  output logic [1:0] exc_code,
  output logic [31:0] busy_regs
);
  import lsu_pkg::*;

  typedef enum logic [1:0] {st_idle, st_mem, st_resp} lsu_state_t;

  function automatic lsu_opinfo_t decode(input lsu_op_t op);
    lsu_opinfo_t d;
    d = '{szm1: SZ_WORD, load: 1'b1, sgn: 1'b0, part: part_none,
          cop: 1'b0, level: LVL_1};
    case (op)
      op_load_byte_signed: begin
        d.szm1 = SZ_BYTE;
        d.sgn = 1'b1;
      end
      op_load_byte_zero_ext: d.szm1 = SZ_BYTE;
      op_load_half_signed: begin
        d.szm1 = SZ_HALF;
        d.sgn = 1'b1;
      end
      op_load_half_zero_ext: d.szm1 = SZ_HALF;
      op_load_word_signed: d.sgn = 1'b1;
      op_load_word_zero_ext: d.level = LVL_3;
      op_load_double: begin
        d.szm1 = SZ_DOUBLE;
        d.level = LVL_3;
      end
      op_store_byte: begin
        d.szm1 = SZ_BYTE;
        d.load = 1'b0;
      end
      op_store_half: begin
        d.szm1 = SZ_HALF;
        d.load = 1'b0;
      end
      op_store_word: d.load = 1'b0;
      op_store_double: begin
        d.szm1 = SZ_DOUBLE;
        d.load = 1'b0;
        d.level = LVL_3;
      end
      op_load_word_left_part: d.part = part_left;
      op_load_word_right_part: d.part = part_right;
      op_store_word_left_part: begin
        d.part = part_left;
        d.load = 1'b0;
      end
      op_store_word_right_part: begin
        d.part = part_right;
        d.load = 1'b0;
      end
      op_load_double_left_part, op_load_double_right_part,
      op_store_double_left_part, op_store_double_right_part: begin
        d.szm1 = SZ_DOUBLE;
        d.level = LVL_3;
        d.load = (op == op_load_double_left_part) ||
                 (op == op_load_double_right_part);
        d.part = ((op == op_load_double_left_part) ||
                  (op == op_store_double_left_part)) ? part_left
                                                      : part_right;
      end
      op_linked_word_load: begin
        d.part = part_linked;
        d.sgn = 1'b1;
        d.level = LVL_2;
      end
      op_conditional_word_store: begin
        d.part = part_cond;
        d.load = 1'b0;
        d.level = LVL_2;
      end
      op_linked_double_load: begin
        d.szm1 = SZ_DOUBLE;
        d.part = part_linked;
        d.level = LVL_3;
      end
      op_conditional_double_store: begin
        d.szm1 = SZ_DOUBLE;
        d.part = part_cond;
        d.load = 1'b0;
        d.level = LVL_3;
      end
      op_cop_load_word: d.cop = 1'b1;
      op_cop_store_word: begin
        d.cop = 1'b1;
        d.load = 1'b0;
      end
      op_cop_load_double, op_cop_store_double: begin
        d.szm1 = SZ_DOUBLE;
        d.cop = 1'b1;
        d.load = (op == op_cop_load_double);
        d.level = LVL_2;
      end
      default: d.load = 1'b1;
    endcase
    return d;
  endfunction : decode

  // Expands a byte-lane mask to a bit mask
  function automatic logic [XLEN-1:0] lane_bits(input logic [7:0] m);
    logic [XLEN-1:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i*8 +: 8] = {8{m[i]}};
    end
    return r;
  endfunction : lane_bits

  lsu_state_t state_q, state_d;
  logic ready_q, ready_d;
  logic mem_valid_q, mem_valid_d;
  lsu_mem_req_t mem_q, mem_d;
  logic wb_valid_q, wb_valid_d;
  lsu_wb_t wb_q, wb_d;
  logic exc_valid_q, exc_valid_d;
  logic [1:0] exc_code_q, exc_code_d;
  logic [31:0] busy_q, busy_d;
  lsu_op_t op_q, op_d;
  logic [XLEN-1:0] ea_q, ea_d;
  logic [XLEN-1:0] mbase_q, mbase_d;
  logic be_q, be_d;
  logic link_valid_q, link_valid_d;
  logic [XLEN-1:0] link_addr_q, link_addr_d;
  logic fwd_valid_q, fwd_valid_d;
  logic [REG_W-1:0] fwd_dest_q, fwd_dest_d;
  logic [XLEN-1:0] fwd_data_q, fwd_data_d;

  lsu_opinfo_t d_in, d_held;
  logic [XLEN-1:0] ea_in, ones, raw, val, lmask, res, sval;
  logic [2:0] ao, boff, kk, lane_sh, rsh;
  logic [7:0] bm8, sm8;
  logic misalign, reserved, unusable, cond_ok;

  always_comb begin
    d_in = decode(req.op);
    d_held = decode(op_q);
    ea_in = req.base + (req.indexed ? req.index
                                    : {{48{req.offset[15]}}, req.offset});

    ao = ea_in[2:0] & ~d_in.szm1;
    boff = ea_in[2:0] & d_in.szm1;
    kk = big_endian ? boff : 3'(d_in.szm1 - boff);
    lane_sh = big_endian ? 3'(3'h7 - ao - d_in.szm1) : ao;
    rsh = 3'(d_in.szm1 - kk);
    bm8 = {{4{d_in.szm1[2]}}, {2{d_in.szm1[1]}}, d_in.szm1[0], 1'b1};
    ones = lane_bits(bm8);

    case (d_in.part)
      part_left: begin
        sm8 = bm8 >> kk;
        sval = (req.src_data & ones) >> {kk, 3'h0};
      end
      part_right: begin
        sm8 = (bm8 << rsh) & bm8;
        sval = req.src_data << {rsh, 3'h0};
      end
      default: begin
        sm8 = bm8;
        sval = req.src_data & ones;
      end
    endcase

    misalign = (d_in.part != part_left) && (d_in.part != part_right) &&
               (boff != 3'h0);
    // unsigned word load from level three
    reserved = (d_in.level > isa_level) ||
               (d_in.cop && (req.copz == COP_SYS));
    if (req.indexed && (!d_in.cop || (req.copz != COP_FPU) ||
                        (isa_level < LVL_4))) begin
      reserved = 1'b1;
    end
    unusable = d_in.cop && !cop_usable[req.copz];
    cond_ok = link_valid_q && (link_addr_q == ea_in);

    // Response side uses the held request
    ao = ea_q[2:0] & ~d_held.szm1;
    boff = ea_q[2:0] & d_held.szm1;
    kk = be_q ? boff : 3'(d_held.szm1 - boff);
    rsh = 3'(d_held.szm1 - kk);
    bm8 = {{4{d_held.szm1[2]}}, {2{d_held.szm1[1]}},
           d_held.szm1[0], 1'b1};
    raw = mem_rdata >> {(be_q ? 3'(3'h7 - ao - d_held.szm1) : ao), 3'h0};
    raw = raw & lane_bits(bm8);

    case (d_held.part)
      part_left: begin
        lmask = lane_bits((bm8 << kk) & bm8);
        val = raw << {kk, 3'h0};
      end
      part_right: begin
        lmask = lane_bits(bm8 >> rsh);
        val = raw >> {rsh, 3'h0};
      end
      default: begin
        lmask = lane_bits(bm8);
        val = raw;
      end
    endcase
    res = (val & lmask) | (mbase_q & ~lmask);
    case (d_held.szm1)
      SZ_BYTE: res = d_held.sgn ? {{56{res[7]}}, res[7:0]}
                                : {56'h0, res[7:0]};
      SZ_HALF: res = d_held.sgn ? {{48{res[15]}}, res[15:0]}
                                : {48'h0, res[15:0]};
      SZ_WORD: res = (d_held.sgn || d_held.part == part_left ||
                      d_held.part == part_right)
                     ? {{32{res[31]}}, res[31:0]} : {32'h0, res[31:0]};
      default: res = res;
    endcase
  end

  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    mem_valid_d = mem_valid_q;
    mem_d = mem_q;
    wb_valid_d = 1'b0;
    wb_d = wb_q;
    exc_valid_d = 1'b0;
    exc_code_d = exc_code_q;
    busy_d = busy_q;
    op_d = op_q;
    ea_d = ea_q;
    mbase_d = mbase_q;
    be_d = be_q;
    link_valid_d = link_valid_q & ~link_break;
    link_addr_d = link_addr_q;
    fwd_valid_d = fwd_valid_q;
    fwd_dest_d = fwd_dest_q;
    fwd_data_d = fwd_data_q;
    case (state_q)
      st_idle: begin
        if (req_valid && ready_q) begin
          fwd_valid_d = 1'b0;
          if (reserved || unusable || misalign) begin
            exc_valid_d = 1'b1;
            exc_code_d = reserved ? EXC_RESERVED
                       : (unusable ? EXC_COP_UNUSABLE : EXC_ADDR);
          end else if (d_in.part == part_cond && !cond_ok) begin
            link_valid_d = 1'b0;
            wb_valid_d = 1'b1;
            wb_d = '{dest: req.dest, to_cop: 1'b0, copz: req.copz,
                     data: DATA_RESET};
          end else begin
            op_d = req.op;
            ea_d = ea_in;
            be_d = big_endian;
            mbase_d = (req.adjacent && fwd_valid_q &&
                       fwd_dest_q == req.dest) ? fwd_data_q
                                               : req.merge_base;
            mem_valid_d = 1'b1;
            mem_d = '{addr: {ea_in[XLEN-1:3], 3'h0}, write: !d_in.load,
                      byte_en: sm8 << lane_sh,
                      wdata: sval << {lane_sh, 3'h0}};
            ready_d = 1'b0;
            state_d = st_mem;
            if (d_in.load && !d_in.cop && isa_level >= LVL_2 &&
                req.dest != '0) begin
              busy_d[req.dest] = 1'b1;
            end
            wb_d.dest = req.dest;
            wb_d.copz = req.copz;
            wb_d.to_cop = d_in.cop;
          end
        end
      end
      st_mem: begin
        if (mem_ready) begin
          mem_valid_d = 1'b0;
          if (mem_q.write) begin
            ready_d = 1'b1;
            state_d = st_idle;
            if (d_held.part == part_cond) begin
              link_valid_d = 1'b0;
              wb_valid_d = 1'b1;
              wb_d.data = 64'h0000_0000_0000_0001;
            end
          end else begin
            state_d = st_resp;
          end
        end
      end
      st_resp: begin
        if (mem_rsp_valid) begin
          wb_valid_d = 1'b1;
          wb_d.data = res;
          busy_d = BUSY_RESET;
          ready_d = 1'b1;
          state_d = st_idle;
          fwd_valid_d = !wb_q.to_cop;
          fwd_dest_d = wb_q.dest;
          fwd_data_d = res;
          if (d_held.part == part_linked) begin
            link_valid_d = 1'b1;
            link_addr_d = ea_q;
          end
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= st_idle;
      ready_q <= 1'b1;
      mem_valid_q <= 1'b0;
      mem_q <= '0;
      wb_valid_q <= 1'b0;
      wb_q <= '0;
      exc_valid_q <= 1'b0;
      exc_code_q <= 2'h0;
      busy_q <= BUSY_RESET;
      op_q <= op_load_byte_signed;
      ea_q <= DATA_RESET;
      mbase_q <= DATA_RESET;
      be_q <= 1'b0;
      link_valid_q <= 1'b0;
      link_addr_q <= DATA_RESET;
      fwd_valid_q <= 1'b0;
      fwd_dest_q <= '0;
      fwd_data_q <= DATA_RESET;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      mem_valid_q <= mem_valid_d;
      mem_q <= mem_d;
      wb_valid_q <= wb_valid_d;
      wb_q <= wb_d;
      exc_valid_q <= exc_valid_d;
      exc_code_q <= exc_code_d;
      busy_q <= busy_d;
      op_q <= op_d;
      ea_q <= ea_d;
      mbase_q <= mbase_d;
      be_q <= be_d;
      link_valid_q <= link_valid_d;
      link_addr_q <= link_addr_d;
      fwd_valid_q <= fwd_valid_d;
      fwd_dest_q <= fwd_dest_d;
      fwd_data_q <= fwd_data_d;
    end
  end

  assign req_ready = ready_q;
  assign mem_valid = mem_valid_q;
  assign mem_req = mem_q;
  assign wb_valid = wb_valid_q;
  assign wb = wb_q;
  assign exc_valid = exc_valid_q;
  assign exc_code = exc_code_q;
  assign busy_regs = busy_q;

endmodule : lsu_top

/* pkg/lsu_pkg.sv */
// Package with types and constants of the load/store unit
package lsu_pkg;

  localparam int XLEN = 64;
  localparam int REG_W = 5;
  localparam int COP_W = 2;

  // Architecture levels
  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h4;

  // Coprocessor numbers with special meaning
  localparam logic [1:0] COP_SYS = 2'h0;
  localparam logic [1:0] COP_FPU = 2'h1;

  // Exception codes
  localparam logic [1:0] EXC_ADDR = 2'h1;
  localparam logic [1:0] EXC_COP_UNUSABLE = 2'h2;
  localparam logic [1:0] EXC_RESERVED = 2'h3;

  // Size codes hold the object size minus one
  localparam logic [2:0] SZ_BYTE = 3'h0;
  localparam logic [2:0] SZ_HALF = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h3;
  localparam logic [2:0] SZ_DOUBLE = 3'h7;

  // Values after reset
  localparam logic [31:0] BUSY_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] DATA_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [4:0] {
    op_load_byte_signed, op_load_byte_zero_ext, op_load_half_signed,
    op_load_half_zero_ext, op_load_word_signed, op_load_word_zero_ext,
    op_load_double, op_store_byte, op_store_half, op_store_word,
    op_store_double, op_load_word_left_part, op_load_word_right_part,
    op_store_word_left_part, op_store_word_right_part,
    op_load_double_left_part, op_load_double_right_part,
    op_store_double_left_part, op_store_double_right_part,
    op_linked_word_load, op_conditional_word_store,
    op_linked_double_load, op_conditional_double_store,
    op_cop_load_word, op_cop_store_word, op_cop_load_double,
    op_cop_store_double
  } lsu_op_t;

  typedef enum logic [2:0] {
    part_none, part_left, part_right, part_linked, part_cond
  } lsu_part_t;

  typedef struct packed {
    lsu_op_t op;
    logic [XLEN-1:0] base;
    logic [15:0] offset;
    logic [XLEN-1:0] index;
    logic indexed;
    logic [REG_W-1:0] dest;
    logic [COP_W-1:0] copz;
    logic [XLEN-1:0] src_data;
    logic [XLEN-1:0] merge_base;
    logic adjacent;
  } lsu_req_t;

  typedef struct packed {
    logic [XLEN-1:0] addr;
    logic write;
    logic [7:0] byte_en;
    logic [XLEN-1:0] wdata;
  } lsu_mem_req_t;

  typedef struct packed {
    logic [REG_W-1:0] dest;
    logic to_cop;
    logic [COP_W-1:0] copz;
    logic [XLEN-1:0] data;
  } lsu_wb_t;

  typedef struct packed {
    logic [2:0] szm1;
    logic load;
    logic sgn;
    lsu_part_t part;
    logic cop;
    logic [2:0] level;
  } lsu_opinfo_t;

endpackage : lsu_pkg

/* tb/lsu_top_asserts.sv */
// Port-level assertions for the load/store unit
`timescale 1ns/1ps
module lsu_top_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] isa_level,
  input wire logic big_endian,
  input wire logic [3:0] cop_usable,
  input wire logic link_break,
  input wire logic req_valid,
  input wire lsu_pkg::lsu_req_t req,
  input wire logic req_ready,
  input wire logic mem_valid,
  input wire lsu_pkg::lsu_mem_req_t mem_req,
  input wire logic mem_ready,
  input wire logic mem_rsp_valid,
  input wire logic [lsu_pkg::XLEN-1:0] mem_rdata,
  input wire logic wb_valid,
  input wire lsu_pkg::lsu_wb_t wb,
  input wire logic exc_valid,
  input wire logic [1:0] exc_code,
  input wire logic [31:0] busy_regs
);
  import lsu_pkg::*;
  logic [XLEN-1:0] eff;
  logic take;
  assign eff = req.base + {{48{req.offset[15]}}, req.offset};
  assign take = req_valid && req_ready && !req.indexed;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  mem_aligned_a: assert property (
    mem_valid |-> mem_req.addr[2:0] == 3'h0) else $error("unaligned memory");
  word_lanes_a: assert property (
    take && req.op == op_store_word && eff[1:0] == 2'h0 |=> mem_valid &&
    mem_req.byte_en == ($past(eff[2] ^ big_endian) ? 8'hF0 : 8'h0F))
    else $error("wrong store lanes");
  misalign_exc_a: assert property (
    take && req.op == op_load_word_signed && eff[1:0] != 2'h0
    |=> exc_valid && exc_code == EXC_ADDR) else $error("no address error");
  double_level_a: assert property (
    take && req.op == op_load_double && isa_level < LVL_3
    |=> exc_valid && exc_code == EXC_RESERVED) else $error("double taken");
  zext_word_level_a: assert property (
    take && req.op == op_load_word_zero_ext && isa_level < LVL_3
    |=> exc_valid && exc_code == EXC_RESERVED) else $error("lwz taken");
  load_busy_a: assert property (
    take && req.op == op_load_word_signed && eff[1:0] == 2'h0 &&
    isa_level >= LVL_2 && req.dest != 5'h0
    |=> busy_regs == (32'h1 << $past(req.dest))) else $error("no interlock");
  rsp_wb_a: assert property (
    mem_rsp_valid |=> wb_valid) else $error("response not written back");
  cop_off_exc_a: assert property (
    take && req.op == op_cop_load_word && req.copz != COP_SYS &&
    !cop_usable[req.copz] |=> exc_valid && exc_code == EXC_COP_UNUSABLE)
    else $error("disabled coprocessor ran");
  fault_quiet_a: assert property (
    exc_valid |-> !mem_valid && !wb_valid && busy_regs == 32'h0)
    else $error("fault with side effect");
  req_hold_a: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("memory request changed");

  cover property (exc_valid && exc_code == EXC_ADDR);
  cover property (wb_valid && wb.to_cop);
  cover property (mem_valid && mem_ready && mem_req.write);
endmodule : lsu_top_asserts

/* tb/lsu_mem_model.sv */
// Behavioural cached memory facing the unit
`timescale 1ns/1ps
module lsu_mem_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_valid,
  input wire lsu_pkg::lsu_mem_req_t mem_req,
  output logic mem_ready,
  output logic mem_rsp_valid,
  output logic [lsu_pkg::XLEN-1:0] mem_rdata
);
  import lsu_pkg::*;
  logic [XLEN-1:0] mem [0:7];
  logic [XLEN-1:0] rd;
  logic [2:0] cnt;
  logic pend;
  int n_acc;
  always @(posedge core_clk) begin
    mem_ready <= 1'h0;
    mem_rsp_valid <= 1'h0;
    // Idle data lines flip so stale data never passes for a reply
    mem_rdata <= ~mem_rdata;
    if (reset) begin
      cnt <= 3'h0;
      pend <= 1'h0;
      n_acc <= 0;
      mem_rdata <= 64'h0;
    end else if (pend) begin
      cnt <= cnt + 3'h1;
      if (cnt >= (slow ? 3'h3 : 3'h0)) begin
        pend <= 1'h0;
        cnt <= 3'h0;
        mem_rsp_valid <= 1'h1;
        mem_rdata <= rd;
      end
    end else if (mem_valid && mem_ready) begin
      n_acc <= n_acc + 1;
      pend <= !mem_req.write;
      rd <= mem[mem_req.addr[5:3]];
      for (int k = 0; k < 8; k++) begin
        if (mem_req.write && mem_req.byte_en[k])
          mem[mem_req.addr[5:3]][8*k +: 8] <= mem_req.wdata[8*k +: 8];
      end
    end else if (mem_valid) begin
      cnt <= cnt + 3'h1;
      if (cnt >= (slow ? 3'h3 : 3'h0)) begin
        mem_ready <= 1'h1;
        cnt <= 3'h0;
      end
    end
  end
endmodule : lsu_mem_model

/* tb/load_store_unit_bench.sv */
// Self-checking bench for the load/store unit
`timescale 1ns/1ps
module load_store_unit_bench;
  import lsu_pkg::*;
  logic core_clk, reset, big_endian, link_break, req_valid, req_ready;
  logic mem_valid, mem_ready, mem_rsp_valid, wb_valid, exc_valid, slow;
  logic [2:0] isa_level;
  logic [3:0] cop_usable;
  logic [1:0] exc_code, got_code;
  logic [31:0] busy_regs;
  logic [XLEN-1:0] mem_rdata;
  lsu_req_t req;
  lsu_mem_req_t mem_req;
  lsu_wb_t wb, got;
  logic [1:0] got_kind;
  int n_errors = 0;
  int samples_checked = 0;

  lsu_top dut (.*);
  lsu_mem_model mem_i (.*);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Offset -8 from base exercises the signed offset add
  task automatic issue(lsu_op_t op, logic [63:0] a, logic [1:0] cz = 2'h1,
    logic [63:0] sdat = 64'h0, logic [63:0] mb = 64'h0, logic adj = 1'h0,
    logic ix = 1'h0);
    int i;
    // Let an edge pass so the strobe never toggles twice in one step
    tick();
    for (i = 0; i < 40 && req_ready !== 1'h1; i++) tick();
    req = '{op: op, base: ix ? 64'h0 : a + 64'h8, offset: ix ? 16'h0 :
      16'hFFF8, index: a, indexed: ix, dest: 5'h3, copz: cz, src_data: sdat,
      merge_base: mb, adjacent: adj};
    req_valid = 1'h1;
    tick();
    req_valid = 1'h0;
    for (i = 0; i < 40; i++) begin
      if (exc_valid === 1'h1 || wb_valid === 1'h1 || req_ready === 1'h1)
        break;
      tick();
    end
    got_kind = {exc_valid, wb_valid};
    got_code = exc_code;
    got = wb;
  endtask : issue

  task automatic want_data(logic [63:0] e);
    chk({62'h0, got_kind}, 64'h1);
    chk(got.data, e);
  endtask : want_data

  task automatic ex(lsu_op_t op, logic [63:0] a, logic [1:0] c,
    logic [1:0] cz = 2'h1, logic ix = 1'h0);
    issue(op, a, cz, 64'h0, 64'h0, 1'h0, ix);
    chk({62'h0, got_kind}, 64'h2);
    chk({62'h0, got_code}, {62'h0, c});
  endtask : ex

  task automatic lchk(logic be, lsu_op_t op, logic [63:0] a, logic [63:0] e);
    big_endian = be;
    issue(op, a);
    want_data(e);
  endtask : lchk

  task automatic t_ext();
    isa_level = LVL_3;
    lchk(1'h0, op_load_byte_signed, 64'h1, 64'hFFFF_FFFF_FFFF_FF97);
    lchk(1'h0, op_load_byte_zero_ext, 64'h1, 64'h97);
    lchk(1'h1, op_load_byte_signed, 64'h1, 64'hFFFF_FFFF_FFFF_FFE2);
    lchk(1'h0, op_load_half_signed, 64'h2, 64'hFFFF_FFFF_FFFF_B5A6);
    lchk(1'h1, op_load_half_zero_ext, 64'h2, 64'hD3C4);
    lchk(1'h1, op_load_word_zero_ext, 64'h4, 64'hB5A6_9788);
    lchk(1'h1, op_load_double, 64'h0, 64'hF1E2_D3C4_B5A6_9788);
    lchk(1'h0, op_load_word_signed, 64'h4, 64'hFFFF_FFFF_F1E2_D3C4);
  endtask : t_ext

  task automatic t_align();
    int n0;
    n0 = mem_i.n_acc;
    ex(op_load_half_signed, 64'h1, EXC_ADDR);
    ex(op_load_word_signed, 64'h2, EXC_ADDR);
    ex(op_load_double, 64'h4, EXC_ADDR);
    ex(op_store_half, 64'h3, EXC_ADDR);
    chk(64'(mem_i.n_acc - n0), 64'h0);
  endtask : t_align

  task automatic t_level();
    isa_level = LVL_2;
    ex(op_load_double, 64'h0, EXC_RESERVED);
    ex(op_load_word_zero_ext, 64'h4, EXC_RESERVED);
    ex(op_linked_double_load, 64'h8, EXC_RESERVED);
    isa_level = LVL_1;
    ex(op_linked_word_load, 64'h8, EXC_RESERVED);
  endtask : t_level

  task automatic t_lock(logic [2:0] lv, logic [31:0] e);
    isa_level = lv;
    slow = 1'h1;
    fork
      issue(op_load_word_signed, 64'h4);
      begin
        repeat (3) tick();
        chk({32'h0, busy_regs}, {32'h0, e});
      end
    join
    want_data(64'hFFFF_FFFF_F1E2_D3C4);
    chk({32'h0, busy_regs}, 64'h0);
    slow = 1'h0;
  endtask : t_lock

  task automatic t_part();
    isa_level = LVL_1;
    big_endian = 1'h1;
    issue(op_load_word_left_part, 64'h1, 2'h1, 64'h0, 64'hAABB_CCDD);
    want_data(64'hFFFF_FFFF_E2D3_C4DD);
    issue(op_load_word_right_part, 64'h4, 2'h1, 64'h0, 64'hAABB_CCDD, 1'h1);
    want_data(64'hFFFF_FFFF_E2D3_C4B5);
    issue(op_store_word_left_part, 64'h1, 2'h1, 64'h1122_3344);
    chk(mem_i.mem[0], 64'hF111_2233_B5A6_9788);
    big_endian = 1'h0;
    issue(op_store_byte, 64'hA, 2'h1, 64'h5A);
    chk(mem_i.mem[1], 64'h0123_4567_895A_CDEF);
    issue(op_store_word, 64'h14, 2'h1, 64'hCAFE_F00D);
    chk({32'h0, mem_i.mem[2][63:32]}, 64'hCAFE_F00D);
  endtask : t_part

  task automatic t_atom();
    isa_level = LVL_2;
    issue(op_linked_word_load, 64'hC);
    want_data(64'h0123_4567);
    issue(op_conditional_word_store, 64'hC, 2'h1, 64'h7654_3210);
    want_data(64'h1);
    issue(op_conditional_word_store, 64'hC, 2'h1, 64'h0);
    want_data(64'h0);
    issue(op_linked_word_load, 64'hC);
    link_break = 1'h1;
    tick();
    link_break = 1'h0;
    issue(op_conditional_word_store, 64'hC, 2'h1, 64'h0);
    want_data(64'h0);
    isa_level = LVL_3;
    issue(op_linked_double_load, 64'h8);
    issue(op_conditional_double_store, 64'h8, 2'h1, 64'h7766_5544_3322_1100);
    want_data(64'h1);
    chk(mem_i.mem[1], 64'h7766_5544_3322_1100);
  endtask : t_atom

  task automatic t_cop();
    isa_level = LVL_1;
    ex(op_cop_load_word, 64'h8, EXC_COP_UNUSABLE);
    cop_usable = 4'h3;
    issue(op_cop_load_word, 64'h8);
    want_data(64'h3322_1100);
    chk({63'h0, got.to_cop}, 64'h1);
    ex(op_cop_load_word, 64'h8, EXC_RESERVED, 2'h0);
    ex(op_cop_load_double, 64'h8, EXC_RESERVED);
    isa_level = LVL_2;
    issue(op_cop_load_double, 64'h8);
    want_data(64'h7766_5544_3322_1100);
    isa_level = LVL_3;
    ex(op_cop_load_word, 64'h8, EXC_RESERVED, 2'h1, 1'h1);
    isa_level = LVL_4;
    issue(op_cop_load_word, 64'h8, 2'h1, 64'h0, 64'h0, 1'h0, 1'h1);
    want_data(64'h3322_1100);
    cop_usable = 4'hF;
    ex(op_cop_load_word, 64'h8, EXC_RESERVED, 2'h2, 1'h1);
  endtask : t_cop

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    reset = 1'h1;
    req_valid = 1'h0;
    req = '0;
    isa_level = LVL_3;
    big_endian = 1'h0;
    cop_usable = 4'h0;
    link_break = 1'h0;
    slow = 1'h0;
    mem_i.mem[0] = 64'hF1E2_D3C4_B5A6_9788;
    mem_i.mem[1] = 64'h0123_4567_89AB_CDEF;
    repeat (8) @(posedge core_clk);
    #1;
    reset = 1'h0;
    t_ext();
    t_align();
    t_level();
    t_lock(LVL_2, 32'h8);
    t_lock(LVL_1, 32'h0);
    t_part();
    t_atom();
    t_cop();
    end_sim();
  end
endmodule : load_store_unit_bench

bind lsu_top lsu_top_asserts chk_i (.*);
